// ==== dv/dsp_spi_far.sv ====
`timescale 1ns/1ps
module dsp_spi_far #(
  parameter logic [7:0] TX = 8'h00
) (
  // Link pins
  input wire sck,
  input wire mosi,
  output wire miso,
  // Byte last taken in
  output logic [7:0] rx_byte
);
  logic [7:0] sh = TX;
  logic [2:0] cnt = 3'h0;
  logic armed = 1'b0;
  // First bit waits on the line before the first edge
  assign miso = sh[7];
  // Clock idles high, so the first (falling) edge captures
  always @(negedge sck) begin
    rx_byte <= {rx_byte[6:0], mosi};
    armed <= 1'b1;
  end
  // Shift only on a rise that follows a capture; power-up rise is ignored
  always @(posedge sck) begin
    if (armed) begin
      cnt <= cnt + 3'h1;
      sh <= (cnt == 3'h7) ? TX : {sh[6:0], ~sh[0]};
      armed <= 1'b0;
    end
  end
endmodule // dsp_spi_far

// ==== dv/dsp_spi_port_bench.sv ====
`timescale 1ns/1ps
`include "dsp_map.vh"
module dsp_spi_port_bench;
  // Bus and link drive
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic sck1 = 1'b0;
  logic mosi1 = 1'b1;
  wire hreadyout, hresp, irq, far_miso;
  wire [31:0] hrdata;
  wire [1:0] sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  wire [1:0] spi_irq;
  wire [7:0] far_rx;
  int errors = 0;
  int checks = 0;
  int cyc;
  logic [31:0] rd;
  logic [7:0] got;
  logic [7:0] regs [8] = '{`DSP_IDX_MODE, `DSP_IDX_CTL1, `DSP_IDX_STS1,
    `DSP_IDX_DAT1, `DSP_IDX_CTL0, `DSP_IDX_STS0, `DSP_IDX_DAT0, 8'h10};
  // Released lines settle at their pull level
  wire [1:0] sck_in = {sck1, sck_oe_n[0] ? 1'b1 : sck_out[0]};
  wire [1:0] mosi_in = {mosi1, mosi_oe_n[0] | mosi_out[0]};
  wire [1:0] miso_in = {miso_oe_n[1] | miso_out[1], far_miso};

  // System clock
  always #5 core_clk = ~core_clk;

  dsp_spi_port dsp_spi_port_inst (.core_clk, .sys_rst, .hsel(1'b1),
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .sck_in, .sck_out, .sck_oe_n, .mosi_in,
    .mosi_out, .mosi_oe_n, .miso_in, .miso_out, .miso_oe_n, .spi_irq, .irq);
  dsp_spi_far #(.TX(8'h96)) dsp_spi_far_inst (.sck(sck_in[0]),
    .mosi(mosi_in[0]), .miso(far_miso), .rx_byte(far_rx));

  task conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Hold a phase until ready is seen at a rising edge
  task hold;
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      rd = hrdata;
      n++;
      @(posedge core_clk);
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    htrans <= 2'h2;
    haddr <= {22'h0, a, 2'h0};
    hwrite <= w;
    hold();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    hold();
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h0, e}, "hrdata");
  endtask
  // Bounded wait for a port interrupt, counting cycles
  task wirq(input int k);
    cyc = 0;
    while (spi_irq[k] !== 1'b1 && cyc < 400) begin
      @(posedge core_clk);
      cyc++;
    end
    if (cyc >= 400) begin
      errors++;
      conclude();
    end
  endtask
  // One frame into the slave port, 160 ns link period, driven on core edges
  task frame(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi1 <= b[i];
      repeat (8) @(posedge core_clk);
      sck1 <= 1'b1;
      got[i] = miso_in[1];
      repeat (8) @(posedge core_clk);
      sck1 <= 1'b0;
    end
    mosi1 <= ~b[0];
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(1'b1, 8'h10, 8'hff);
    foreach (regs[i]) rdc(regs[i], 8'h00);
    bus(1'b1, `DSP_IDX_CTL0, 8'h10);
    repeat (2) @(negedge core_clk);
    chk({31'h0, sck_out[0]}, 32'h1, "idle clock");
    bus(1'b1, `DSP_IDX_MODE, 8'h50);
    rdc(`DSP_IDX_MODE, 8'h50);
    bus(1'b1, `DSP_IDX_CTL0, 8'hf1);
    rdc(`DSP_IDX_CTL0, 8'hb1);
    bus(1'b1, `DSP_IDX_STS0, 8'h01);
    // Second load while busy is dropped
    bus(1'b1, `DSP_IDX_DAT0, 8'ha5);
    bus(1'b1, `DSP_IDX_DAT0, 8'h3c);
    wirq(0);
    chk({31'h0, cyc >= 56 && cyc <= 72}, 32'h1, "bit time");
    chk({24'h0, far_rx}, 32'ha5, "far byte");
    rdc(`DSP_IDX_DAT0, 8'h96);
    rdc(`DSP_IDX_STS0, 8'hc9);
    bus(1'b1, `DSP_IDX_IRQ_EN, 8'h01);
    repeat (2) @(negedge core_clk);
    chk({31'h0, irq}, 32'h1, "irq");
    bus(1'b1, `DSP_IDX_IRQ_CLR, 8'h01);
    bus(1'b1, `DSP_IDX_STS0, 8'hc8);
    repeat (2) @(negedge core_clk);
    chk({29'h0, irq, spi_irq}, 32'h0, "irq lines");
    bus(1'b1, `DSP_IDX_STS0, 8'h05);
    rdc(`DSP_IDX_STS0, 8'h05);
    bus(1'b1, `DSP_IDX_DAT0, 8'h12);
    wirq(0);
    chk({24'h0, far_rx}, 32'h48, "far byte");
    rdc(`DSP_IDX_DAT0, 8'h69);
    // Port 1 as slave, nothing loaded
    bus(1'b1, `DSP_IDX_CTL1, 8'h80);
    bus(1'b1, `DSP_IDX_STS1, 8'h01);
    frame(8'hc3);
    chk({24'h0, got}, 32'h0, "slave out");
    wirq(1);
    rdc(`DSP_IDX_DAT1, 8'hc3);
    frame(8'h5a);
    rdc(`DSP_IDX_DAT1, 8'hc3);
    bus(1'b1, `DSP_IDX_MODE, 8'h80);
    rdc(`DSP_IDX_MODE, 8'h80);
    chk({30'h0, sck_oe_n}, 32'h3, "clock drive");
    conclude();
  end
endmodule // dsp_spi_port_bench

// ==== dv/dsp_spi_port_sva.sv ====
`timescale 1ns/1ps
module dsp_spi_port_sva (
  // Clock, reset and bus
  input wire core_clk,
  input wire sys_rst,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // Serial pins and interrupts
  input wire [1:0] sck_out,
  input wire [1:0] sck_oe_n,
  input wire [1:0] mosi_out,
  input wire [1:0] mosi_oe_n,
  input wire [1:0] miso_out,
  input wire [1:0] miso_oe_n,
  input wire [1:0] spi_irq,
  input wire irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Zero wait states and never an error answer
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer bad");
  a_rdata_pad: assert property (hrdata[31:8] == 24'h0)
    else $error("read pad set");
  // Read data lives for one data phase only
  a_rdata_drop: assert property (
    !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
    else $error("read data unasked");
  // A port never drives as master and slave at once
  a_role_excl: assert property ((mosi_oe_n | miso_oe_n) == 2'h3)
    else $error("both roles drive");
  a_clk_drive: assert property (sck_oe_n == mosi_oe_n)
    else $error("clock drive mismatch");
  a_tx_same: assert property (mosi_out == miso_out)
    else $error("shift outputs differ");
  // Fastest rate is four cycles a bit, so a level lasts two cycles
  a_half_zero: assert property (
    !sck_oe_n[0] && !$past(sck_oe_n[0]) && $changed(sck_out[0])
    |=> $stable(sck_out[0]) || sck_oe_n[0]) else $error("clock 0 fast");
  a_half_one: assert property (
    !sck_oe_n[1] && !$past(sck_oe_n[1]) && $changed(sck_out[1])
    |=> $stable(sck_out[1]) || sck_oe_n[1]) else $error("clock 1 fast");
  // Main traffic seen
  c_done0: cover property ($rose(spi_irq[0]));
  c_done1: cover property ($rose(spi_irq[1]));
  c_irq: cover property ($rose(irq));
endmodule // dsp_spi_port_sva

bind dsp_spi_port dsp_spi_port_sva dsp_spi_port_sva_inst (.core_clk,
  .sys_rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .sck_out, .sck_oe_n, .mosi_out, .mosi_oe_n, .miso_out, .miso_oe_n,
  .spi_irq, .irq);

// ==== hw/dsp_map.vh ====
`ifndef DSP_MAP_VH
`define DSP_MAP_VH

// Register indices; byte address is four times the index
`define DSP_IDX_MODE 8'h8f
`define DSP_IDX_CTL1 8'h9d
`define DSP_IDX_STS1 8'h9e
`define DSP_IDX_DAT1 8'h9f
`define DSP_IDX_CTL0 8'ha5
`define DSP_IDX_STS0 8'ha6
`define DSP_IDX_DAT0 8'ha7
`define DSP_IDX_IRQ_STAT 8'hb0
`define DSP_IDX_IRQ_CLR 8'hb1
`define DSP_IDX_IRQ_EN 8'hb2

// Mode field encodings
`define DSP_MODE_OFF 2'h0
`define DSP_MODE_SPI 2'h1
`define DSP_MODE_TWI 2'h2
`define DSP_MODE_UART 2'h3

// Control register fields
`define DSP_CTL_ON 7
`define DSP_CTL_ROLE 5
`define DSP_CTL_IDLE 4
`define DSP_CTL_EDGE 3

// Status register fields
`define DSP_STS_DONE 7
`define DSP_STS_WRITE_COLLISION_FLAG 6
`define DSP_STS_TXE 3
`define DSP_STS_ORD 2
`define DSP_STS_IE 0

// Reset values
`define DSP_RST_BYTE 8'h00

// Half of the smallest divisor (4); doubled per rate step
`define DSP_HALF_BASE 9'h002
`define DSP_BITS_LAST 4'h7

`endif

// ==== hw/dsp_spi_port.v ====
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dsp_map.vh"

// Overview of operation
// - Mode bits 7:6 select port 1 function
// - Mode bits 5:4 select port 0 function
// - Control bit 7 enables the shifter
// - Control bit 5 picks master or slave
// - Control bit 4 sets clock idle level
// - Control bit 3 picks the sampling edge
// - Rate bits divide system clock 4..512
// - Done flag set by hardware, software clears
// - Collision flag set on conflicting write
// - Buffer empty flag, software clears it
// - Status bit 2 picks bit order
// - Interrupt when done flag and enable
// - Data write loads tx, read returns rx
// - Two independent ports, separate addresses
// - Busy write flags collision, byte continues
// - Slave sends zero byte when unloaded
// - Slave holds received byte until cleared
// - Eight clock periods per full duplex byte
module dsp_spi_port (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // Serial pins, bit n serves port n
  input wire [1:0] sck_in,
  output wire [1:0] sck_out,
  output wire [1:0] sck_oe_n,
  input wire [1:0] mosi_in,
  output wire [1:0] mosi_out,
  output wire [1:0] mosi_oe_n,
  input wire [1:0] miso_in,
  output wire [1:0] miso_out,
  output wire [1:0] miso_oe_n,
  // Interrupts
  output wire [1:0] spi_irq,
  output wire irq
);

  reg [7:0] idx_r;
  reg wr_pend_r;
  reg [31:0] hrdata_r;
  reg [7:2] mode_r;
  reg [3:0] istat_r;
  reg [3:0] ien_r;
  reg [7:0] rd_nxt;
  wire [15:0] ctl_w;
  wire [15:0] sts_w;
  wire [15:0] rx_w;
  wire [1:0] ev_done;
  wire [1:0] ev_write_collision_flag;
  wire [3:0] ev_all;
  wire ap_take;
  wire ap_hit;
  wire [7:0] wd;

  // Sticky flag update: a hardware set in the same cycle beats the clear,
  // so an event that lands on a software clear is never lost
  function sticky;
    input cur;
    input set;
    input clr;
    begin
      sticky = set | (cur & ~clr);
    end
  endfunction

  // One step of a byte shifter in either bit order; the receive and the
  // transmit shifter share it so both always move the same way
  function [7:0] shift8;
    input [7:0] cur;
    input in_bit;
    input lsb_first;
    begin
      if (lsb_first)
        shift8 = {in_bit, cur[7:1]};
      else
        shift8 = {cur[6:0], in_bit};
    end
  endfunction

  // Bus timing summary:
  // the address phase is taken on the edge where hsel, htrans and hready
  // are all high; index and direction are kept for the data phase.
  // Writes land on the edge that closes the data phase, when hwdata is
  // valid, so no write data ever needs to be held by this block.
  // Reads are answered from a register loaded at the end of the address
  // phase; the value stands for exactly one data phase and then drops.
  // Trade-off: a read of the data register that races a shift edge sees
  // the byte as it stood in the address phase, one cycle before the data phase.

  // Zero wait state slave: every access finishes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign ap_take = hsel & htrans[1] & hready;
  assign ap_hit = (haddr[31:10] == 22'h0);
  assign wd = hwdata[7:0];

  // Read mux; write-only and unmapped locations read as zero
  always @* begin
    case (haddr[9:2])
      `DSP_IDX_MODE: rd_nxt = {mode_r, 2'h0};
      `DSP_IDX_CTL0: rd_nxt = ctl_w[7:0];
      `DSP_IDX_STS0: rd_nxt = sts_w[7:0];
      `DSP_IDX_DAT0: rd_nxt = rx_w[7:0];
      `DSP_IDX_CTL1: rd_nxt = ctl_w[15:8];
      `DSP_IDX_STS1: rd_nxt = sts_w[15:8];
      `DSP_IDX_DAT1: rd_nxt = rx_w[15:8];
      `DSP_IDX_IRQ_STAT: rd_nxt = {4'h0, istat_r};
      `DSP_IDX_IRQ_EN: rd_nxt = {4'h0, ien_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  // Address phase capture; read data is registered for the data phase
  always @(posedge core_clk) begin
    if (sys_rst) begin
      idx_r <= 8'h00;
      wr_pend_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= ap_take & hwrite & ap_hit;
      idx_r <= haddr[9:2];
      if (ap_take & ~hwrite & ap_hit)
        hrdata_r <= {24'h00_0000, rd_nxt};
      else
        hrdata_r <= 32'h0000_0000;
    end
  end

  // Mode register and interrupt bookkeeping; a new event beats a clear
  assign ev_all = {ev_write_collision_flag[1], ev_done[1], ev_write_collision_flag[0], ev_done[0]};
  assign irq = |(istat_r & ien_r);
  always @(posedge core_clk) begin
    if (sys_rst) begin
      mode_r <= 6'h00;
      istat_r <= 4'h0;
      ien_r <= 4'h0;
    end else begin
      if (wr_pend_r && idx_r == `DSP_IDX_MODE)
        mode_r <= wd[7:2];
      if (wr_pend_r && idx_r == `DSP_IDX_IRQ_EN)
        ien_r <= wd[3:0];
      if (wr_pend_r && idx_r == `DSP_IDX_IRQ_CLR)
        istat_r <= ev_all | (istat_r & ~wd[3:0]);
      else
        istat_r <= ev_all | istat_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : port
      reg [7:0] ctl_r;
      reg done_r;
      reg write_collision_flag_r;
      reg txe_r;
      reg ord_r;
      reg ie_r;
      reg [7:0] tx_sh_r;
      reg [7:0] rx_sh_r;
      reg tx_full_r;
      reg busy_r;
      reg lvl_r;
      reg [3:0] tcnt_r;
      reg [8:0] div_r;
      reg sck_s1_r;
      reg sck_s2_r;
      reg sck_s3_r;
      reg mi_s1_r;
      reg mi_s2_r;
      reg mo_s1_r;
      reg mo_s2_r;
      wire [7:0] ctl_idx;
      wire [7:0] sts_idx;
      wire [7:0] dat_idx;
      wire [1:0] mode;
      wire on;
      wire mst;
      wire clock_idle_level;
      wire clock_sample_edge;
      wire [8:0] half_m1;
      wire mtick;
      wire slv_edge;
      wire lead;
      wire trail;
      wire samp;
      wire shft;
      wire done;
      wire rx_bit;
      wire tx_bit;
      wire wr_ctl;
      wire wr_sts;
      wire wr_dat;
      wire coll;
      wire load;

      // Port timing summary:
      // the master starts one cycle after a byte is loaded while idle and
      // toggles its clock every half period of 2 << rate system clocks.
      // A slave sees pin edges two to three cycles late through the
      // synchronisers, so the external clock must stay below one eighth
      // of the system clock for every edge to be seen.
      // Leading and trailing edges are worked out from the idle level, so
      // the same shift logic serves both roles and all four clock forms.
      // The done flag rises with the eighth trailing edge of a byte.

      // Each port has its own address set and mode field
      assign ctl_idx = (g == 0) ? `DSP_IDX_CTL0 : `DSP_IDX_CTL1;
      assign sts_idx = (g == 0) ? `DSP_IDX_STS0 : `DSP_IDX_STS1;
      assign dat_idx = (g == 0) ? `DSP_IDX_DAT0 : `DSP_IDX_DAT1;
      assign mode = (g == 0) ? mode_r[5:4] : mode_r[7:6];
      assign on = ctl_r[`DSP_CTL_ON] && (mode == `DSP_MODE_SPI);
      assign mst = ctl_r[`DSP_CTL_ROLE];
      assign clock_idle_level = ctl_r[`DSP_CTL_IDLE];
      assign clock_sample_edge = ctl_r[`DSP_CTL_EDGE];

      // Half period is 2..256 system clocks, so one bit is 4..512
      assign half_m1 = (`DSP_HALF_BASE << ctl_r[2:0]) - 9'h001;
      assign mtick = on & mst & busy_r & (div_r == half_m1);

      // Slave edges come from comparing the second and third sync stages
      assign slv_edge = on & ~mst & ~done_r & (sck_s2_r ^ sck_s3_r);
      assign lead = mst ? (mtick & ~lvl_r) : (slv_edge & (sck_s2_r ^ clock_idle_level));
      assign trail = mst ? (mtick & lvl_r) : (slv_edge & ~(sck_s2_r ^ clock_idle_level));
      assign samp = clock_sample_edge ? trail : lead;
      assign shft = clock_sample_edge ? (lead & (tcnt_r != 4'h0)) : trail;
      assign done = trail & (tcnt_r == `DSP_BITS_LAST);
      assign rx_bit = mst ? mi_s2_r : mo_s2_r;
      assign tx_bit = ord_r ? tx_sh_r[0] : tx_sh_r[7];

      assign wr_ctl = wr_pend_r && (idx_r == ctl_idx);
      assign wr_sts = wr_pend_r && (idx_r == sts_idx);
      assign wr_dat = wr_pend_r && (idx_r == dat_idx);
      // A write while a byte is pending or moving is refused
      assign coll = wr_dat & (tx_full_r | busy_r);
      assign load = wr_dat & ~tx_full_r & ~busy_r;

      // Pin synchronisers
      always @(posedge core_clk) begin
        if (sys_rst) begin
          sck_s1_r <= 1'b0;
          sck_s2_r <= 1'b0;
          sck_s3_r <= 1'b0;
          mi_s1_r <= 1'b0;
          mi_s2_r <= 1'b0;
          mo_s1_r <= 1'b0;
          mo_s2_r <= 1'b0;
        end else begin
          sck_s1_r <= sck_in[g];
          sck_s2_r <= sck_s1_r;
          sck_s3_r <= sck_s2_r;
          mi_s1_r <= miso_in[g];
          mi_s2_r <= mi_s1_r;
          mo_s1_r <= mosi_in[g];
          mo_s2_r <= mo_s1_r;
        end
      end

      // Shifter, clock generator and software registers
      always @(posedge core_clk) begin
        if (sys_rst) begin
          ctl_r <= `DSP_RST_BYTE;
          ord_r <= 1'b0;
          ie_r <= 1'b0;
          tx_sh_r <= `DSP_RST_BYTE;
          rx_sh_r <= `DSP_RST_BYTE;
          tx_full_r <= 1'b0;
          busy_r <= 1'b0;
          lvl_r <= 1'b0;
          tcnt_r <= 4'h0;
          div_r <= 9'h000;
        end else begin
          if (wr_ctl)
            ctl_r <= {wd[7], 1'b0, wd[5:0]};
          if (wr_sts) begin
            ord_r <= wd[`DSP_STS_ORD];
            ie_r <= wd[`DSP_STS_IE];
          end
          // Switching off abandons any byte in flight
          if (!on) begin
            busy_r <= 1'b0;
            lvl_r <= 1'b0;
            tcnt_r <= 4'h0;
            div_r <= 9'h000;
          end else begin
            if (mst & ~busy_r & tx_full_r) begin
              busy_r <= 1'b1;
              div_r <= 9'h000;
            end
            if (mst & busy_r) begin
              div_r <= mtick ? 9'h000 : div_r + 9'h001;
              if (mtick)
                lvl_r <= ~lvl_r;
            end
            if (~mst & lead)
              busy_r <= 1'b1;
            // Receive and transmit move on opposite edges of one bit
            if (samp)
              rx_sh_r <= shift8(rx_sh_r, rx_bit, ord_r);
            // Zero fill so a byte that is not reloaded goes out as zero
            if (shft)
              tx_sh_r <= shift8(tx_sh_r, 1'b0, ord_r);
            if (trail)
              tcnt_r <= tcnt_r + 4'h1;
            if (done) begin
              busy_r <= 1'b0;
              tcnt_r <= 4'h0;
              tx_full_r <= 1'b0;
              tx_sh_r <= `DSP_RST_BYTE;
            end
          end
          if (load) begin
            tx_sh_r <= wd;
            tx_full_r <= 1'b1;
          end
        end
      end

      // Sticky flags: hardware set wins over a software clear
      always @(posedge core_clk) begin
        if (sys_rst) begin
          done_r <= 1'b0;
          write_collision_flag_r <= 1'b0;
          txe_r <= 1'b0;
        end else begin
          // Software clears a flag by writing 0 to it; writing 1 keeps it
          done_r <= sticky(done_r, done,
            wr_sts & ~wd[`DSP_STS_DONE]);
          write_collision_flag_r <= sticky(write_collision_flag_r, coll,
            wr_sts & ~wd[`DSP_STS_WRITE_COLLISION_FLAG]);
          // Empty flag also drops when a new byte is accepted
          txe_r <= done |
            (txe_r & ~load & ~(wr_sts & ~wd[`DSP_STS_TXE]));
        end
      end

      // Pin drive: master owns clock and out line, slave the return line
      assign sck_out[g] = clock_idle_level ^ lvl_r;
      assign sck_oe_n[g] = ~(on & mst);
      assign mosi_out[g] = tx_bit;
      assign mosi_oe_n[g] = ~(on & mst);
      assign miso_out[g] = tx_bit;
      assign miso_oe_n[g] = ~(on & ~mst);

      assign spi_irq[g] = done_r & ie_r;
      assign ev_done[g] = done;
      assign ev_write_collision_flag[g] = coll;
      assign ctl_w[g*8 +: 8] = ctl_r;
      assign sts_w[g*8 +: 8] = {done_r, write_collision_flag_r, 2'h0, txe_r, ord_r, 1'b0,
                                ie_r};
      assign rx_w[g*8 +: 8] = rx_sh_r;
    end
  endgenerate

endmodule // dsp_spi_port
